// ### core/ppmux_top.sv
/*
 Parallel port multiplexer: four 8-bit port latches on the special-function
 bus, pin drivers with pull-up and open-drain behaviour, the external memory
 bus on ports 0 and 2, and programmer-mode pin reassignment.
 Assumes the core gives a state-six-phase-two strobe and a state-one-phase-one
 strobe as single-cycle enables on core_clk, and that the mode input is static.
*/
`timescale 1ns/1ps

module ppmux_top (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // Mode: 1 running mode, 0 programmer mode
    input  wire logic                  in_system_running_mode,
    // Machine-cycle phase strobes
    input  wire logic                  s6p2_strobe,
    input  wire logic                  s1p1_strobe,
    // Special-function register port
    input  wire logic [7:0]            sfr_addr,
    input  wire logic                  sfr_wr,
    input  wire logic                  sfr_rd,
    input  wire logic                  sfr_rmw,
    input  wire logic [7:0]            sfr_wdata,
    output logic      [7:0]            sfr_rdata,
    output logic                       sfr_hit,
    // External bus and alternate functions from the core
    input  wire ppmux_pkg::ppmux_ext_t ext_req,
    input  wire ppmux_pkg::ppmux_alt_t alt_out,
    output logic      [7:0]            ext_rdata,
    // Alternate-function inputs to peripherals
    output logic                       serial_receive_pin,
    output logic                       external_irq_zero,
    output logic                       external_irq_one,
    output logic                       timer_zero_count_input,
    output logic                       timer_one_count_input,
    output logic                       second_timer_count_input,
    output logic                       second_timer_capture_trigger,
    // Programmer-mode interface to the flash logic
    output logic      [15:0]           prog_addr,
    output logic      [7:0]            prog_data_in,
    output logic      [3:0]            prog_ctrl,
    input  wire logic [7:0]            prog_data_out,
    input  wire logic                  prog_verify,
    // Pins: input, output, output enable (enable high while driving)
    input  wire logic [31:0]           pin_in,
    output logic      [31:0]           pin_out,
    output logic      [31:0]           pin_oe,
    output logic      [31:0]           pin_pullup
);
    import ppmux_pkg::*;

    logic [7:0]  port_zero_latch;
    logic [7:0]  port_one_latch;
    logic [7:0]  port_two_latch;
    logic [7:0]  port_three_latch;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] pin_level;
    logic [31:0] next_out;
    logic [31:0] next_oe;
    logic [7:0]  wr_hold;
    logic [1:0]  wr_sel;
    logic        wr_pend;
    logic        wr_commit;
    logic        run;
    logic [2:0]  sfr_dec;

    // Decode a register address into a port index; valid flag in bit 2
    function automatic logic [2:0] port_decode(input logic [7:0] a);
        case (a)
            PPMUX_OFF_PORT0: port_decode = 3'h4;
            PPMUX_OFF_PORT1: port_decode = 3'h5;
            PPMUX_OFF_PORT2: port_decode = 3'h6;
            PPMUX_OFF_PORT3: port_decode = 3'h7;
            default:         port_decode = 3'h0;
        endcase
    endfunction

    assign run = in_system_running_mode;

    // Register address decode shared by the write capture and the read mux
    assign sfr_dec = port_decode(sfr_addr);

    // capture the write
    // The write is held until state six phase two so it lands at the
    // documented moment even when the core presents it earlier.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_hold <= 8'h00;
            wr_sel  <= 2'h0;
        end else if (sfr_wr && sfr_dec[2]) begin
            wr_pend <= 1'b1;
            wr_hold <= sfr_wdata;
            wr_sel  <= sfr_dec[1:0];
        end else if (s6p2_strobe) begin
            wr_pend <= 1'b0;
        end
    end

    assign wr_commit = wr_pend && s6p2_strobe;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_zero_latch  <= PPMUX_LATCH_RST;
            port_one_latch   <= PPMUX_LATCH_RST;
            port_two_latch   <= PPMUX_LATCH_RST;
            port_three_latch <= PPMUX_LATCH_RST;
        end else if (wr_commit) begin
            case (wr_sel)
                2'h0:    port_zero_latch  <= wr_hold;
                2'h1:    port_one_latch   <= wr_hold;
                2'h2:    port_two_latch   <= wr_hold;
                default: port_three_latch <= wr_hold;
            endcase
        end
    end

    // Three-stage pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1     <= '1;
            sync2     <= '1;
            sync3     <= '1;
            pin_level <= '1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 32; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_level[i] <= sync3[i];
                end
            end
        end
    end

    // Pin drive selection per mode
    always_comb begin
        next_out = '1;
        next_oe  = '0;
        if (run) begin
            if (ext_req.active) begin
                if (ext_req.ale) begin
                    next_out[7:0] = ext_req.addr[7:0];
                    next_oe[7:0]  = 8'hff;
                end else if (ext_req.data_out) begin
                    next_out[7:0] = ext_req.wdata;
                    next_oe[7:0]  = 8'hff;
                end
            end else begin
                next_out[7:0] = 8'h00;
                next_oe[7:0]  = ~port_zero_latch;
            end
            // ports 1 and 3 pull down where latch is zero
            next_out[15:8] = port_one_latch;
            next_oe[15:8]  = ~port_one_latch;
            if (ext_req.active && ext_req.wide_addr) begin
                next_out[23:16] = ext_req.addr[15:8];
                next_oe[23:16]  = 8'hff;
            end else begin
                next_out[23:16] = port_two_latch;
                next_oe[23:16]  = ~port_two_latch;
            end
            next_out[31:24] = port_three_latch;
            next_oe[31:24]  = ~port_three_latch;
            // alternate outputs gated by latch one
            // serial transmit and strobes on port 3
            if (port_three_latch[PPMUX_PORT3_TXD]) begin
                next_out[24 + PPMUX_PORT3_TXD] = alt_out.txd;
                next_oe[24 + PPMUX_PORT3_TXD]  = ~alt_out.txd;
            end
            if (port_three_latch[PPMUX_PORT3_WR]) begin
                next_out[24 + PPMUX_PORT3_WR] = alt_out.wr_n;
                next_oe[24 + PPMUX_PORT3_WR]  = ~alt_out.wr_n;
            end
            if (port_three_latch[PPMUX_PORT3_RD]) begin
                next_out[24 + PPMUX_PORT3_RD] = alt_out.rd_n;
                next_oe[24 + PPMUX_PORT3_RD]  = ~alt_out.rd_n;
            end
        end else begin
            // programmer data port: drive only during verify
            // programmer mode leaves ports 1 to 3 as inputs
            next_out[7:0] = prog_data_out;
            next_oe[7:0]  = prog_verify ? 8'hff : 8'h00;
        end
    end

    // pins follow at state one phase one, and every cycle during external access or in programmer mode
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '1;
            pin_oe  <= '0;
        end else if (s1p1_strobe || ext_req.active || !run) begin
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

    // pull-ups on ports 1 to 3 only in running mode
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_pullup <= PPMUX_PULLUP_RUN;
        end else begin
            pin_pullup <= run ? PPMUX_PULLUP_RUN : 32'h0;
        end
    end

    always_comb begin
        sfr_hit   = sfr_rd && sfr_dec[2];
        sfr_rdata = 8'h00;
        if (sfr_hit) begin
            case (sfr_dec[1:0])
                2'h0:    sfr_rdata = sfr_rmw ? port_zero_latch  : pin_level[7:0];
                2'h1:    sfr_rdata = sfr_rmw ? port_one_latch   : pin_level[15:8];
                2'h2:    sfr_rdata = sfr_rmw ? port_two_latch   : pin_level[23:16];
                default: sfr_rdata = sfr_rmw ? port_three_latch : pin_level[31:24];
            endcase
        end
    end

    // External read data is the port 0 pin level
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_rdata <= 8'h00;
        end else begin
            ext_rdata <= pin_level[7:0];
        end
    end

    // alternate inputs gated by latch one
    // peripheral inputs; assumed kept by software
    // Gated inputs read high so a disabled function sees an idle line.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_receive_pin           <= 1'b1;
            external_irq_zero            <= 1'b1;
            external_irq_one             <= 1'b1;
            timer_zero_count_input       <= 1'b1;
            timer_one_count_input        <= 1'b1;
            second_timer_count_input     <= 1'b1;
            second_timer_capture_trigger <= 1'b1;
        end else begin
            serial_receive_pin           <= pin_level[24 + PPMUX_PORT3_RXD]  | ~port_three_latch[PPMUX_PORT3_RXD];
            external_irq_zero            <= pin_level[24 + PPMUX_PORT3_IRQ0] | ~port_three_latch[PPMUX_PORT3_IRQ0];
            external_irq_one             <= pin_level[24 + PPMUX_PORT3_IRQ1] | ~port_three_latch[PPMUX_PORT3_IRQ1];
            timer_zero_count_input       <= pin_level[24 + PPMUX_PORT3_TMR0] | ~port_three_latch[PPMUX_PORT3_TMR0];
            timer_one_count_input        <= pin_level[24 + PPMUX_PORT3_TMR1] | ~port_three_latch[PPMUX_PORT3_TMR1];
            second_timer_count_input     <= pin_level[8 + PPMUX_PORT1_CNT2]  | ~port_one_latch[PPMUX_PORT1_CNT2];
            second_timer_capture_trigger <= pin_level[8 + PPMUX_PORT1_CAP2]  | ~port_one_latch[PPMUX_PORT1_CAP2];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_addr    <= 16'h0000;
            prog_data_in <= 8'h00;
            prog_ctrl    <= 4'h0;
        end else if (!run) begin
            prog_addr    <= {pin_level[29:28], pin_level[21:16], pin_level[15:8]};
            prog_data_in <= pin_level[7:0];
            prog_ctrl    <= {pin_level[31:30], pin_level[23:22]};
        end
    end

    // Assertions
    a_latch_reset_val: assert property (@(posedge core_clk) $fell(sys_rst) |-> port_one_latch == 8'hff)
        else $error("latch not ff after reset");
    a_write_at_s6p2: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr_pend && s6p2_strobe && wr_sel == 2'h1) |=> port_one_latch == $past(wr_hold))
        else $error("latch write missed state six");
    a_p0_open_drain: assert property (@(posedge core_clk) disable iff (sys_rst)
        (run && !ext_req.active && s1p1_strobe) |=> (pin_oe[7:0] == ~$past(port_zero_latch)) && pin_out[7:0] == 8'h00)
        else $error("port 0 not open drain");
    a_ale_addr_out: assert property (@(posedge core_clk) disable iff (sys_rst)
        (run && ext_req.active && ext_req.ale) |=> pin_out[7:0] == $past(ext_req.addr[7:0]) && pin_oe[7:0] == 8'hff)
        else $error("low address missing");
    a_hi_addr_strong: assert property (@(posedge core_clk) disable iff (sys_rst)
        (run && ext_req.active && ext_req.wide_addr) |=> pin_oe[23:16] == 8'hff)
        else $error("high address not strong");
    a_indirect_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (run && ext_req.active && !ext_req.wide_addr) |=> pin_out[23:16] == $past(port_two_latch))
        else $error("port 2 latch not shown");
    a_rmw_reads_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_rd && sfr_rmw && sfr_addr == PPMUX_OFF_PORT2) |-> sfr_rdata == port_two_latch)
        else $error("rmw did not read latch");
    a_prog_addr_map: assert property (@(posedge core_clk) disable iff (sys_rst)
        !run |=> prog_addr[7:0] == $past(pin_level[15:8]))
        else $error("flash low address wrong");
    a_alt_gate_rxd: assert property (@(posedge core_clk) disable iff (sys_rst)
        !port_three_latch[PPMUX_PORT3_RXD] |=> serial_receive_pin)
        else $error("receive not gated by latch");
    a_prog_p0_hiz: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!run && !prog_verify) |=> pin_oe[7:0] == 8'h00)
        else $error("port 0 driven in program");

    // pin update slots
    // An update slot is a state-one strobe with no external access; between
    // slots the pin registers must hold so a new latch value waits its turn.
    sequence s_pin_slot;
        run && !ext_req.active && s1p1_strobe;
    endsequence
    sequence s_pin_idle;
        run && !ext_req.active && !s1p1_strobe;
    endsequence
    a_pin_at_s1p1: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_pin_slot |=> pin_oe[15:8] == ~$past(port_one_latch))
        else $error("port 1 pins missed state one");
    a_pin_hold_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_pin_idle |=> $stable(pin_oe) && $stable(pin_out))
        else $error("pins moved between update slots");

    // only the four latch addresses answer
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_rd && !sfr_dec[2]) |-> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");

endmodule // ppmux_top

// ### core/ppmux_pkg.sv
/*
 Package for the parallel port multiplexer: register offsets, reset values,
 field positions and the carrier structs shared by the port block.
 Assumes a core that owns the special-function bus and the machine-cycle timing.
*/
package ppmux_pkg;
    // Latch register addresses on the special-function bus
    localparam logic [7:0] PPMUX_OFF_PORT0 = 8'h80;
    localparam logic [7:0] PPMUX_OFF_PORT1 = 8'h90;
    localparam logic [7:0] PPMUX_OFF_PORT2 = 8'ha0;
    localparam logic [7:0] PPMUX_OFF_PORT3 = 8'hb0;
    // Latch value after reset
    localparam logic [7:0] PPMUX_LATCH_RST = 8'hff;
    // Number of ports and bits per port
    localparam int PPMUX_NPORT = 4;
    localparam int PPMUX_WIDTH = 8;
    // Port 3 alternate-function bit positions
    localparam int PPMUX_PORT3_RXD  = 0;
    localparam int PPMUX_PORT3_TXD  = 1;
    localparam int PPMUX_PORT3_IRQ0 = 2;
    localparam int PPMUX_PORT3_IRQ1 = 3;
    localparam int PPMUX_PORT3_TMR0 = 4;
    localparam int PPMUX_PORT3_TMR1 = 5;
    localparam int PPMUX_PORT3_WR   = 6;
    localparam int PPMUX_PORT3_RD   = 7;
    // Port 1 alternate-function bit positions
    localparam int PPMUX_PORT1_CNT2 = 0;
    localparam int PPMUX_PORT1_CAP2 = 1;
    // Pull-up enables in running mode: ports 1 to 3 on, port 0 open drain
    localparam logic [31:0] PPMUX_PULLUP_RUN = 32'hffffff00;
    // Pin synchroniser depth
    localparam int PPMUX_SYNC_STAGES = 3;

    // One port's pin drive: output level and enable per bit
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ppmux_drive_t;

    // External bus request from the core
    typedef struct packed {
        logic       active;     // External access in progress
        logic       ale;        // Address latch strobe
        logic       wide_addr;  // Code fetch or pointer access: high byte on port 2
        logic       data_out;   // Core drives data in the data phase
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ppmux_ext_t;

    // Core-side alternate-function outputs on port 3
    typedef struct packed {
        logic txd;
        logic wr_n;
        logic rd_n;
    } ppmux_alt_t;
endpackage : ppmux_pkg

// ### dv/ppmux_pin_model.sv
/*
 Pin-side model of the parallel ports: resolves each pin from the block's drive,
 external drive requested by the bench, internal pull-ups, or floating.
 Assumes the bench drives ext_en/ext_val on core_clk and the block drives pins.
*/
`timescale 1ns/1ps
module ppmux_pin_model (
    // Clock
    input  wire logic        core_clk,
    // Block side of the pins
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pin_pullup,
    // Outside circuitry
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    output logic      [31:0] pin_in
);
    logic [31:0] float_lvl = '0;

    // floating pin: toggles so a stale value never reads as valid
    always_ff @(posedge core_clk) begin
        float_lvl <= ~pin_in;
    end

    // pull-up or outside pull; block drive wins, contention not modelled
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & pin_pullup) | (~pin_oe & ~ext_en & ~pin_pullup & float_lvl);
    end
endmodule // ppmux_pin_model

// ### dv/ppmux_top_bench.sv
/*
 Self-checking bench for the port multiplexer: register access, latch timing,
 pin versus latch reads, alternate gating, external bus and programmer mode.
 Assumes the pin model above and a machine cycle of six core_clk cycles.
*/
`timescale 1ns/1ps
module ppmux_top_bench;
    import ppmux_pkg::*;
    logic core_clk, sys_rst, in_system_running_mode, s6p2_strobe, s1p1_strobe;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ext_rdata, prog_data_in, prog_data_out, d;
    logic sfr_wr, sfr_rd, sfr_rmw, sfr_hit, prog_verify, h;
    logic serial_receive_pin, external_irq_zero, external_irq_one, timer_zero_count_input;
    logic timer_one_count_input, second_timer_count_input, second_timer_capture_trigger;
    logic [15:0] prog_addr;
    logic [3:0] prog_ctrl;
    logic [31:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
    ppmux_ext_t ext_req;
    ppmux_alt_t alt_out;
    int failures, n_checks, cycles;
    logic [2:0] mc_cnt;

    ppmux_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .in_system_running_mode(in_system_running_mode),
        .s6p2_strobe(s6p2_strobe), .s1p1_strobe(s1p1_strobe), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .ext_req(ext_req), .alt_out(alt_out), .ext_rdata(ext_rdata), .serial_receive_pin(serial_receive_pin),
        .external_irq_zero(external_irq_zero), .external_irq_one(external_irq_one),
        .timer_zero_count_input(timer_zero_count_input), .timer_one_count_input(timer_one_count_input),
        .second_timer_count_input(second_timer_count_input),
        .second_timer_capture_trigger(second_timer_capture_trigger), .prog_addr(prog_addr),
        .prog_data_in(prog_data_in), .prog_ctrl(prog_ctrl), .prog_data_out(prog_data_out),
        .prog_verify(prog_verify), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    ppmux_pin_model u_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // Clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Machine-cycle strobes: s6p2 then s1p1 on consecutive cycles
    always @(posedge core_clk) begin
        mc_cnt <= (mc_cnt == 3'd5) ? 3'd0 : mc_cnt + 3'd1;
        s6p2_strobe <= (mc_cnt == 3'd4);
        s1p1_strobe <= (mc_cnt == 3'd5);
    end

    // Hang guard: the run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic do_reset(input logic m);
        sys_rst <= 1'b1;
        in_system_running_mode <= m;
        cyc(3);
        sys_rst <= 1'b0;
        cyc(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        cyc(1);
        sfr_wr <= 1'b0;
        cyc(1);
    endtask

    // Read data is combinational, so it is taken at the edge ending the request
    task automatic rd(input logic [7:0] a, input logic m);
        sfr_addr <= a;
        sfr_rmw <= m;
        sfr_rd <= 1'b1;
        cyc(1);
        d = sfr_rdata;
        h = sfr_hit;
        sfr_rd <= 1'b0;
        cyc(1);
    endtask

    task automatic t_reset_vals;
        logic [7:0] offs [4];
        offs = '{PPMUX_OFF_PORT0, PPMUX_OFF_PORT1, PPMUX_OFF_PORT2, PPMUX_OFF_PORT3};
        foreach (offs[i]) begin
            rd(offs[i], 1'b1);
            chk({h, d}, {1'b1, PPMUX_LATCH_RST});
        end
        rd(8'h84, 1'b0);
        chk({h, d}, 9'h000);
        chk(pin_oe, 32'h0);
        chk(pin_pullup, 32'hffffff00);
        $display("test reset_vals done");
    endtask

    task automatic t_latch_timing;
        while (s1p1_strobe !== 1'b1) @(posedge core_clk);
        wr(PPMUX_OFF_PORT1, 8'h55);
        while (s6p2_strobe !== 1'b1) @(posedge core_clk);
        #1 chk(pin_oe[15:8], 8'h00);
        @(posedge core_clk);
        #1 chk(pin_oe[15:8], 8'haa);
        @(posedge core_clk);
        $display("test latch_timing done");
    endtask

    task automatic t_pin_vs_latch;
        ext_en[15:8] <= 8'hff;
        ext_val[15:8] <= 8'h00;
        cyc(8);
        rd(PPMUX_OFF_PORT1, 1'b0);
        chk(d, 8'h00);
        rd(PPMUX_OFF_PORT1, 1'b1);
        chk(d, 8'h55);
        chk(second_timer_count_input, 1'b0);
        chk(second_timer_capture_trigger, 1'b1);
        ext_en[15:8] <= 8'h00;
        $display("test pin_vs_latch done");
    endtask

    task automatic t_open_drain;
        wr(PPMUX_OFF_PORT0, 8'h0f);
        cyc(14);
        chk(pin_oe[7:0], 8'hf0);
        $display("test open_drain done");
    endtask

    task automatic t_alt_gate;
        wr(PPMUX_OFF_PORT3, 8'hfe);
        ext_en[31:24] <= 8'h04;
        ext_val[31:24] <= 8'h00;
        alt_out <= '{txd: 1'b0, wr_n: 1'b1, rd_n: 1'b0};
        cyc(14);
        chk(serial_receive_pin, 1'b1);
        chk(external_irq_zero, 1'b0);
        chk({external_irq_one, timer_zero_count_input, timer_one_count_input}, 3'h7);
        chk(pin_in[25], 1'b0);
        chk(pin_in[31:30], 2'b01);
        alt_out <= '{txd: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
        ext_en[31:24] <= 8'h00;
        $display("test alt_gate done");
    endtask

    task automatic t_ext_bus;
        wr(PPMUX_OFF_PORT2, 8'h3c);
        cyc(14);
        ext_req <= '{active: 1'b1, ale: 1'b1, wide_addr: 1'b1, data_out: 1'b0, addr: 16'h1234, wdata: 8'ha5};
        cyc(3);
        chk({pin_out[23:16], pin_out[7:0]}, 16'h1234);
        chk({pin_oe[23:16], pin_oe[7:0]}, 16'hffff);
        ext_req.ale <= 1'b0;
        ext_req.data_out <= 1'b1;
        cyc(3);
        chk({pin_oe[7:0], pin_out[7:0]}, 16'hffa5);
        ext_req.wide_addr <= 1'b0;
        cyc(3);
        chk(pin_in[23:16], 8'h3c);
        ext_req.data_out <= 1'b0;
        ext_en[7:0] <= 8'hff;
        ext_val[7:0] <= 8'h5a;
        cyc(8);
        chk(ext_rdata, 8'h5a);
        ext_en[7:0] <= 8'h00;
        ext_req <= '0;
        cyc(3);
        $display("test ext_bus done");
    endtask

    task automatic t_prog;
        do_reset(1'b0);
        ext_en <= 32'hffffffff;
        ext_val <= 32'h10c35a69;
        cyc(8);
        chk(prog_addr, 16'h435a);
        chk(prog_ctrl, 4'h3);
        chk(prog_data_in, 8'h69);
        chk(pin_pullup, 32'h0);
        ext_en[7:0] <= 8'h00;
        prog_data_out <= 8'h96;
        prog_verify <= 1'b1;
        cyc(3);
        chk({pin_oe[7:0], pin_out[7:0]}, 16'hff96);
        prog_verify <= 1'b0;
        ext_en <= 32'h0;
        do_reset(1'b1);
        $display("test prog done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {sys_rst, in_system_running_mode, sfr_wr, sfr_rd, sfr_rmw, prog_verify} = 6'b110000;
        {sfr_addr, sfr_wdata, prog_data_out, mc_cnt} = '0;
        {s6p2_strobe, s1p1_strobe} = 2'b00;
        {ext_en, ext_val} = '0;
        ext_req = '0;
        alt_out = '{txd: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
        do_reset(1'b1);
        t_reset_vals();
        t_latch_timing();
        t_pin_vs_latch();
        t_open_drain();
        t_alt_gate();
        t_ext_bus();
        t_prog();
        results();
    end
endmodule // ppmux_top_bench
